// ==== src/iow_cfg.svh ====
`ifndef IOW_CFG_SVH
`define IOW_CFG_SVH

// Register offsets of the output page, byte addresses of 16-bit words.
`define IOW_PAGE_SEL_OFS 7'h00
`define IOW_RATE_X_FINE_OFS 7'h10
`define IOW_RATE_X_MAIN_OFS 7'h12
`define IOW_RATE_Y_FINE_OFS 7'h14
`define IOW_RATE_Y_MAIN_OFS 7'h16
`define IOW_RATE_Z_FINE_OFS 7'h18
`define IOW_RATE_Z_MAIN_OFS 7'h1A
`define IOW_ACCEL_X_FINE_OFS 7'h1C
`define IOW_ACCEL_X_MAIN_OFS 7'h1E
`define IOW_ACCEL_Y_FINE_OFS 7'h20
`define IOW_ACCEL_Y_MAIN_OFS 7'h22
`define IOW_ACCEL_Z_FINE_OFS 7'h24
`define IOW_ACCEL_Z_MAIN_OFS 7'h26

// Reset values.
`define IOW_PAGE_SEL_RST 16'h0000
`define IOW_DATA_RST 32'h0000_0000

// Full-scale counts of the main words.
`define IOW_RATE_FULL_SCALE 16'h57E4
`define IOW_ACCEL_FULL_SCALE 16'h4E20

// Serial frame layout.
`define IOW_FRAME_BITS 5'h10
`define IOW_CMD_WRITE_BIT 15
`define IOW_ADDR_MSB 14
`define IOW_ADDR_LSB 8
`define IOW_WDATA_MSB 7

`endif

// ==== src/iow_pkg.sv ====
package iow_pkg;

    typedef enum logic [1:0] {
        IOW_SPI_IDLE = 2'b00,
        IOW_SPI_SHIFT = 2'b01,
        IOW_SPI_DONE = 2'b10
    } iow_spi_state_t;

    typedef logic [31:0] iow_sample_t;
    typedef logic [15:0] iow_word_t;

endpackage

// ==== src/iow_clamp.sv ====
`include "iow_cfg.svh"

module iow_clamp #(
    parameter logic [15:0] LIMIT = `IOW_RATE_FULL_SCALE
) (
    // Raw 32-bit measurement.
    input wire logic [31:0] raw_i,
    // Clamped measurement.
    output logic [31:0] clamped_o
);

    localparam logic signed [31:0] MAX_VAL = {LIMIT, 16'h0000};
    localparam logic signed [31:0] MIN_VAL = -MAX_VAL;

    // A limit of zero or one with the sign bit set cannot be mirrored into a negative bound.
    if (LIMIT == 16'h0000 || LIMIT[15])
    begin : g_bad_limit
        $error("iow_clamp: LIMIT must be positive and below 0x8000");
    end

    always_comb
    begin
        if ($signed(raw_i) > MAX_VAL)
        begin
            clamped_o = MAX_VAL;
        end
        else if ($signed(raw_i) < MIN_VAL)
        begin
            clamped_o = MIN_VAL;
        end
        else
        begin
            clamped_o = raw_i;
        end
    end

endmodule // iow_clamp

// ==== src/iow_top.sv ====
// Function
// - Rate main word: 0.02 deg/s per LSB.
// - Rate main word clamped to +-22500 counts.
// - Rate fine word: MSB 0.01 deg/s.
// - Rate main words at 0x12, 0x16, 0x1A.
// - Rate fine words at 0x10, 0x14, 0x18.
// - Accel main: 0.25 mg LSB, +-20000 clamp.
// - Accel fine word: MSB 0.125 mg.
// - Accel main words at 0x1E, 0x22, 0x26.
// - Accel fine words at 0x1C, 0x20, 0x24.
// - Main upper, fine lower of 32 bits.
// - Page selector is zero after reset.
`include "iow_cfg.svh"

module iow_top (
    // Clock, reset and clock enable.
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    // Sample stream from the sensor front end.
    input wire logic SAMPLE_VALID_I,
    input wire logic [31:0] SAMPLE_RATE_X_I,
    input wire logic [31:0] SAMPLE_RATE_Y_I,
    input wire logic [31:0] SAMPLE_RATE_Z_I,
    input wire logic [31:0] SAMPLE_ACCEL_X_I,
    input wire logic [31:0] SAMPLE_ACCEL_Y_I,
    input wire logic [31:0] SAMPLE_ACCEL_Z_I,
    // Serial register port.
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_MOSI_I,
    output logic SPI_MISO_O,
    output logic SPI_MISO_OE_O,
    // Current page.
    output logic [15:0] PAGE_SEL_O
);

    localparam int NUM_CH = 6;
    localparam int PIN_SCLK = 2;
    localparam int PIN_CS_N = 1;
    localparam int PIN_MOSI = 0;

    // Channel order: rate x, y, z then accel x, y, z.
    iow_pkg::iow_sample_t raw_w [NUM_CH];
    iow_pkg::iow_sample_t clamped_w [NUM_CH];
    iow_pkg::iow_sample_t data_q [NUM_CH];
    iow_pkg::iow_word_t fine_hold_q [NUM_CH];

    assign raw_w[0] = SAMPLE_RATE_X_I;
    assign raw_w[1] = SAMPLE_RATE_Y_I;
    assign raw_w[2] = SAMPLE_RATE_Z_I;
    assign raw_w[3] = SAMPLE_ACCEL_X_I;
    assign raw_w[4] = SAMPLE_ACCEL_Y_I;
    assign raw_w[5] = SAMPLE_ACCEL_Z_I;

    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] pin_q;
    logic [2:0] pin_prev_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic cs_active;

    iow_pkg::iow_spi_state_t state_q;
    logic [4:0] bit_cnt_q;
    logic [15:0] rx_q;
    logic [15:0] tx_q;
    logic [15:0] reply_q;
    logic [15:0] page_q;
    logic miso_q;

    logic [15:0] rd_data;
    logic rd_main;
    logic rd_fine;
    logic [2:0] rd_ch;
    logic [6:0] cmd_addr;
    logic frame_end;

    // The front end delivers values already scaled, so only the range limit is applied here.
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++)
        begin : g_ch
            iow_clamp #(
                .LIMIT(g < 3 ? `IOW_RATE_FULL_SCALE : `IOW_ACCEL_FULL_SCALE)
            ) u_clamp (
                .raw_i(raw_w[g]),
                .clamped_o(clamped_w[g])
            );

            always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
            begin
                if (SYS_RST_I)
                begin
                    data_q[g] <= `IOW_DATA_RST;
                end
                else if (CE_I && SAMPLE_VALID_I)
                begin
                    data_q[g] <= clamped_w[g];
                end
            end

            // Reading the main word freezes its partner, so a later fine read matches it.
            // same-sample pairing
            always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
            begin
                if (SYS_RST_I)
                begin
                    fine_hold_q[g] <= 16'h0000;
                end
                else if (CE_I && frame_end && !rx_q[`IOW_CMD_WRITE_BIT] && page_q == `IOW_PAGE_SEL_RST
                         && rd_main && rd_ch == 3'(g))
                begin
                    fine_hold_q[g] <= data_q[g][15:0];
                end
            end
        end
    endgenerate

    // Pins are asynchronous; a level is accepted once stages two and three agree.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            sync1_q <= 3'h6;
            sync2_q <= 3'h6;
            sync3_q <= 3'h6;
            pin_q <= 3'h6;
            pin_prev_q <= 3'h6;
        end
        else if (CE_I)
        begin
            sync1_q <= {SPI_SCLK_I, SPI_CS_N_I, SPI_MOSI_I};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q <= (sync2_q & sync3_q) | (pin_q & (sync2_q ^ sync3_q));
            pin_prev_q <= pin_q;
        end
    end

    assign cs_active = !pin_q[PIN_CS_N];
    assign sclk_rise = pin_q[PIN_SCLK] && !pin_prev_q[PIN_SCLK];
    assign sclk_fall = !pin_q[PIN_SCLK] && pin_prev_q[PIN_SCLK];
    assign cs_fall = !pin_q[PIN_CS_N] && pin_prev_q[PIN_CS_N];
    assign cs_rise = pin_q[PIN_CS_N] && !pin_prev_q[PIN_CS_N];
    assign frame_end = cs_rise && state_q == iow_pkg::IOW_SPI_DONE;
    assign cmd_addr = {rx_q[`IOW_ADDR_MSB:`IOW_ADDR_LSB + 1], 1'b0};

    // Frame sequencing; a frame cut short leaves no effect.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            state_q <= iow_pkg::IOW_SPI_IDLE;
            bit_cnt_q <= 5'h00;
            rx_q <= 16'h0000;
        end
        else if (CE_I)
        begin
            case (state_q)
                iow_pkg::IOW_SPI_IDLE:
                begin
                    if (cs_fall)
                    begin
                        state_q <= iow_pkg::IOW_SPI_SHIFT;
                        bit_cnt_q <= 5'h00;
                    end
                end
                iow_pkg::IOW_SPI_SHIFT:
                begin
                    if (cs_rise)
                    begin
                        state_q <= iow_pkg::IOW_SPI_IDLE;
                    end
                    else if (sclk_rise)
                    begin
                        rx_q <= {rx_q[14:0], pin_q[PIN_MOSI]};
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                        if (bit_cnt_q + 5'h01 == `IOW_FRAME_BITS)
                        begin
                            state_q <= iow_pkg::IOW_SPI_DONE;
                        end
                    end
                end
                iow_pkg::IOW_SPI_DONE:
                begin
                    if (cs_rise)
                    begin
                        state_q <= iow_pkg::IOW_SPI_IDLE;
                    end
                end
                default:
                begin
                    state_q <= iow_pkg::IOW_SPI_IDLE;
                end
            endcase
        end
    end

    // Mode 3: first bit is ready at select, later bits move on falling clock.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            tx_q <= 16'h0000;
            miso_q <= 1'b0;
        end
        else if (CE_I)
        begin
            if (cs_fall)
            begin
                tx_q <= reply_q;
                miso_q <= reply_q[15];
            end
            else if (state_q == iow_pkg::IOW_SPI_SHIFT && sclk_fall && bit_cnt_q != 5'h00)
            begin
                tx_q <= {tx_q[14:0], 1'b0};
                miso_q <= tx_q[14];
            end
        end
    end

    // Address decode of the output page.
    always_comb
    begin
        rd_main = 1'b0;
        rd_fine = 1'b0;
        rd_ch = 3'h0;
        case (cmd_addr)
            `IOW_RATE_X_FINE_OFS: begin rd_fine = 1'b1; rd_ch = 3'h0; end
            `IOW_RATE_Y_FINE_OFS: begin rd_fine = 1'b1; rd_ch = 3'h1; end
            `IOW_RATE_Z_FINE_OFS: begin rd_fine = 1'b1; rd_ch = 3'h2; end
            `IOW_RATE_X_MAIN_OFS: begin rd_main = 1'b1; rd_ch = 3'h0; end
            `IOW_RATE_Y_MAIN_OFS: begin rd_main = 1'b1; rd_ch = 3'h1; end
            `IOW_RATE_Z_MAIN_OFS: begin rd_main = 1'b1; rd_ch = 3'h2; end
            `IOW_ACCEL_X_FINE_OFS: begin rd_fine = 1'b1; rd_ch = 3'h3; end
            `IOW_ACCEL_Y_FINE_OFS: begin rd_fine = 1'b1; rd_ch = 3'h4; end
            `IOW_ACCEL_Z_FINE_OFS: begin rd_fine = 1'b1; rd_ch = 3'h5; end
            `IOW_ACCEL_X_MAIN_OFS: begin rd_main = 1'b1; rd_ch = 3'h3; end
            `IOW_ACCEL_Y_MAIN_OFS: begin rd_main = 1'b1; rd_ch = 3'h4; end
            `IOW_ACCEL_Z_MAIN_OFS: begin rd_main = 1'b1; rd_ch = 3'h5; end
            default: begin rd_ch = 3'h0; end
        endcase
    end

    always_comb
    begin
        rd_data = 16'h0000;
        if (cmd_addr == `IOW_PAGE_SEL_OFS)
        begin
            rd_data = page_q;
        end
        else if (page_q == `IOW_PAGE_SEL_RST && rd_main)
        begin
            rd_data = data_q[rd_ch][31:16];
        end
        else if (page_q == `IOW_PAGE_SEL_RST && rd_fine)
        begin
            rd_data = fine_hold_q[rd_ch];
        end
    end

    // A read's answer travels in the next frame, as the port is full duplex.
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            reply_q <= 16'h0000;
        end
        else if (CE_I && frame_end)
        begin
            reply_q <= rx_q[`IOW_CMD_WRITE_BIT] ? 16'h0000 : rd_data;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            page_q <= `IOW_PAGE_SEL_RST;
        end
        else if (CE_I && frame_end && rx_q[`IOW_CMD_WRITE_BIT] && cmd_addr == `IOW_PAGE_SEL_OFS)
        begin
            page_q <= {8'h00, rx_q[`IOW_WDATA_MSB:0]};
        end
    end

    assign SPI_MISO_O = miso_q;
    assign SPI_MISO_OE_O = cs_active;
    assign PAGE_SEL_O = page_q;

endmodule // iow_top

// ==== verif/iow_top_checker.sv ====
module iow_top_checker (
    // Clock and reset.
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CE_I,
    // Serial port.
    input wire logic SPI_SCLK_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_MISO_O,
    input wire logic SPI_MISO_OE_O,
    // Page.
    input wire logic [15:0] PAGE_SEL_O
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence cs_low_5;
        (!SPI_CS_N_I && CE_I) [*5];
    endsequence
    sequence cs_high_5;
        (SPI_CS_N_I && CE_I) [*5];
    endsequence
    // Seven cycles outlast the pin filter, so no edge of either line is still pending.
    sequence sclk_high_7;
        (SPI_SCLK_I && !SPI_CS_N_I) [*7];
    endsequence

    page_after_reset_a: assert property ($fell(SYS_RST_I) |-> PAGE_SEL_O == 16'h0000 && !SPI_MISO_OE_O)
        else $error("page or enable wrong after reset");
    oe_idle_low_a: assert property (cs_high_5 |-> !SPI_MISO_OE_O)
        else $error("miso enabled while deselected");
    oe_frame_high_a: assert property (cs_low_5 |-> SPI_MISO_OE_O)
        else $error("miso not enabled in frame");
    oe_rise_late_a: assert property ($fell(SPI_CS_N_I) && CE_I |-> ##[2:5] SPI_MISO_OE_O)
        else $error("miso enable late");
    oe_drop_late_a: assert property ($rose(SPI_CS_N_I) && CE_I |-> ##[2:5] !SPI_MISO_OE_O)
        else $error("miso enable held too long");
    miso_bit_hold_a: assert property (sclk_high_7 |=> $stable(SPI_MISO_O))
        else $error("miso moved while clock high");
    page_frame_only_a: assert property ($changed(PAGE_SEL_O) |-> SPI_CS_N_I)
        else $error("page changed inside frame");
    page_ce_gate_a: assert property ($changed(PAGE_SEL_O) |-> $past(CE_I))
        else $error("page changed with enable low");
endmodule // iow_top_checker

bind iow_top iow_top_checker CHK (.SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
    .SPI_SCLK_I(SPI_SCLK_I), .SPI_CS_N_I(SPI_CS_N_I), .SPI_MISO_O(SPI_MISO_O),
    .SPI_MISO_OE_O(SPI_MISO_OE_O), .PAGE_SEL_O(PAGE_SEL_O));

// ==== verif/iow_host.sv ====
module iow_host (
    // Clock.
    input wire logic clk_i,
    // Serial lines.
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // One mode 3 frame; half sets each clock phase in system cycles, 6 being the least allowed.
    task automatic frame(input logic [15:0] cmd, input int half, output logic [15:0] rsp);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (half) @(posedge clk_i);
        for (int i = 15; i >= 0; i--)
        begin
            sclk_o <= 1'b0;
            mosi_o <= cmd[i];
            repeat (half) @(posedge clk_i);
            rsp[i] = miso_i;
            sclk_o <= 1'b1;
            repeat (half) @(posedge clk_i);
        end
        cs_n_o <= 1'b1;
        // A released line must not keep showing the last bit.
        mosi_o <= ~mosi_o;
        repeat (10) @(posedge clk_i);
    endtask
endmodule // iow_host

// ==== verif/iow_top_tb.sv ====
module iow_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, ce, vld, sclk, cs_n, mosi, miso, oe;
    logic [15:0] page, d;
    logic [31:0] smp [6];
    logic [15:0] ex_hi [6], ex_lo [6];
    logic [6:0] mains [6] = '{7'h12, 7'h16, 7'h1A, 7'h1E, 7'h22, 7'h26};
    int n_mismatch = 0;
    int n_tests = 0;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    iow_top DUT (.SYS_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .SAMPLE_VALID_I(vld),
        .SAMPLE_RATE_X_I(smp[0]), .SAMPLE_RATE_Y_I(smp[1]), .SAMPLE_RATE_Z_I(smp[2]),
        .SAMPLE_ACCEL_X_I(smp[3]), .SAMPLE_ACCEL_Y_I(smp[4]), .SAMPLE_ACCEL_Z_I(smp[5]),
        .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n), .SPI_MOSI_I(mosi), .SPI_MISO_O(miso),
        .SPI_MISO_OE_O(oe), .PAGE_SEL_O(page));
    iow_host HOST (.clk_i(clk), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));

    task summarize();
        if (n_mismatch == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // The reply arrives in the following frame, at the fastest legal clock.
    task rd(input logic [6:0] a, output logic [15:0] v);
        HOST.frame({1'b0, a, 8'h00}, 8, d);
        HOST.frame(16'h0000, 6, v);
    endtask

    task load(input logic [31:0] a, b, c, e, f, g);
        @(posedge clk);
        smp <= '{a, b, c, e, f, g};
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
    endtask

    task check_all();
        for (int k = 0; k < 6; k++)
        begin
            rd(mains[k], d);
            chk("main word", ex_hi[k], d);
            rd(mains[k] - 7'h02, d);
            chk("fine word", ex_lo[k], d);
        end
    endtask

    task s_reset();
        chk("page pin", 16'h0000, page);
        chk("miso enable idle", 16'h0000, {15'h0000, oe});
        rd(7'h12, d);
        chk("zero rate", 16'h0000, d);
    endtask

    task s_map();
        load(32'h0001_8000, 32'hFFFE_4000, 32'h1234_5678, 32'h4E20_0000, 32'hB1E0_0000, 32'hFFFF_FFFF);
        ex_hi = '{16'h0001, 16'hFFFE, 16'h1234, 16'h4E20, 16'hB1E0, 16'hFFFF};
        ex_lo = '{16'h8000, 16'h4000, 16'h5678, 16'h0000, 16'h0000, 16'hFFFF};
        check_all();
    endtask

    task s_clamp();
        load(32'h7000_0000, 32'h8000_0000, 32'h57E4_0001, 32'h4E20_0001, 32'hB1DF_FFFF, 32'h0000_0001);
        ex_hi = '{16'h57E4, 16'hA81C, 16'h57E4, 16'h4E20, 16'hB1E0, 16'h0000};
        ex_lo = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};
        check_all();
    endtask

    task s_hold();
        load(32'hAAAA_5555, 0, 0, 0, 0, 0);
        rd(7'h12, d);
        chk("main before update", 16'hAAAA, d);
        load(32'h1111_2222, 0, 0, 0, 0, 0);
        rd(7'h10, d);
        chk("captured fine", 16'h5555, d);
        @(posedge clk);
        ce <= 1'b0;
        load(32'h3333_4444, 0, 0, 0, 0, 0);
        @(posedge clk);
        ce <= 1'b1;
        rd(7'h12, d);
        chk("frozen main", 16'h1111, d);
        rd(7'h10, d);
        chk("new fine", 16'h2222, d);
    endtask

    task s_page();
        // The unmapped read must happen on page zero, or the page gate alone would zero it.
        rd(7'h28, d);
        chk("unmapped", 16'h0000, d);
        HOST.frame(16'h8001, 12, d);
        chk("page set", 16'h0001, page);
        HOST.frame(16'h0000, 6, d);
        chk("write reply", 16'h0000, d);
        rd(7'h00, d);
        chk("page readback", 16'h0001, d);
        rd(7'h12, d);
        chk("off page data", 16'h0000, d);
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("page after reset", 16'h0000, page);
    endtask

    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        vld = 1'b0;
        smp = '{default: 32'h0000_0000};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        s_reset();
        s_map();
        s_clamp();
        s_hold();
        s_page();
        summarize();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
endmodule // iow_top_tb
